// ===== oms_asserts.sv
// checker: mode entry, locks and hand-over properties at the selector ports
`timescale 1ns/1ps
module oms_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [oms_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire oms_pkg::oms_term_s termPins,
  input wire oms_pkg::oms_analog_s analogIn,
  input wire oms_pkg::oms_panel_s panelIn,
  input wire oms_pkg::oms_net_s netIn,
  input wire oms_pkg::oms_drive_s driveCmd,
  input wire oms_pkg::oms_mode_e opMode,
  input wire logic panelWriteAck,
  input wire logic panelWriteNak
);
  logic [oms_pkg::SET_W-1:0] setReg;
  logic stopEn;
  logic cfgWr;
  logic modeReq;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  assign cfgWr = psel && penable && pwrite && pready && paddr == oms_pkg::OFF_CTRL;
  assign modeReq = panelIn.panelUnitModeKey || panelIn.extModeKey || netIn.toNetCmd;
  // mirror of the accepted setting and stop key enable
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      setReg <= oms_pkg::SETTING_RESET;
      stopEn <= oms_pkg::STOP_KEY_EN_RESET;
    end
    else if (cfgWr)
    begin
      stopEn <= pwdata[oms_pkg::CTRL_STOP_EN_BIT];
      if (!driveCmd.run && pwdata[2:0] != 3'h5 && pwdata[2:0] != 3'h7)
        setReg <= pwdata[2:0];
    end
  end
  property p_ack;
    panelIn.paramWrite && opMode != oms_pkg::MODE_EXT |=> panelWriteAck && !panelWriteNak;
  endproperty
  a_ack: assert property (p_ack) else $error("panel write not acked");
  property p_nak;
    panelIn.paramWrite && opMode == oms_pkg::MODE_EXT && !panelIn.paramExempt
      |=> panelWriteNak && !panelWriteAck;
  endproperty
  a_nak: assert property (p_nak) else $error("panel write not refused");
  property p_stop;
    panelIn.stopKey && stopEn |=> !driveCmd.run;
  endproperty
  a_stop: assert property (p_stop) else $error("stop key ignored");
  property p_lock1;
    setReg == oms_pkg::SET_PU_FIXED |-> opMode == oms_pkg::MODE_PU;
  endproperty
  a_lock1: assert property (p_lock1) else $error("setting 1 left panel mode");
  property p_lock3;
    setReg == oms_pkg::SET_COMB_PANEL_FREQ |-> opMode == oms_pkg::MODE_COMB_PF;
  endproperty
  a_lock3: assert property (p_lock3) else $error("setting 3 mode wrong");
  property p_lock2;
    setReg == oms_pkg::SET_EXT_FIXED |-> opMode != oms_pkg::MODE_PU;
  endproperty
  a_lock2: assert property (p_lock2) else $error("setting 2 reached panel");
  property p_sw0;
    setReg == oms_pkg::SET_EXT_SWITCH && opMode == oms_pkg::MODE_EXT && !driveCmd.run
      && panelIn.panelUnitModeKey && !cfgWr |=> opMode == oms_pkg::MODE_PU;
  endproperty
  a_sw0: assert property (p_sw0) else $error("panel key refused");
  property p_t2p;
    setReg == oms_pkg::SET_SWITCHOVER && opMode == oms_pkg::MODE_EXT
      && panelIn.panelUnitModeKey && !cfgWr |=> opMode == oms_pkg::MODE_PU
      ##1 driveCmd[16:0] == $past(driveCmd[16:0], 2);
  endproperty
  a_t2p: assert property (p_t2p) else $error("panel hand-over lost");
  property p_t2n;
    setReg == oms_pkg::SET_SWITCHOVER && opMode == oms_pkg::MODE_EXT && netIn.toNetCmd
      && !panelIn.panelUnitModeKey && !panelIn.extModeKey && !cfgWr
      |=> opMode == oms_pkg::MODE_NET ##1 driveCmd[16:0] == $past(driveCmd[16:0], 2);
  endproperty
  a_t2n: assert property (p_t2n) else $error("network hand-over lost");
  property p_runcfg;
    cfgWr && driveCmd.run && !modeReq && !netIn.toExtCmd |=> $stable(opMode);
  endproperty
  a_runcfg: assert property (p_runcfg) else $error("mode moved on running write");
endmodule
bind oms_mode_selector oms_asserts oms_asserts_i (.*);

// ===== oms_far_side.sv
// far side model: control terminals, analog words, operator panel, network master
`timescale 1ns/1ps
module oms_far_side (
  input wire logic ref_clk,
  output oms_pkg::oms_term_s termPins,
  output oms_pkg::oms_analog_s analogIn,
  output oms_pkg::oms_panel_s panelIn,
  output oms_pkg::oms_net_s netIn
);
  initial
  begin
    termPins = '0;
    analogIn = '0;
    panelIn = '0;
    netIn = '0;
  end
  // terminal levels hold until the next call
  task automatic term(input logic [6:0] t);
    termPins <= t;
  endtask
  task automatic ana(input logic [15:0] v, input logic [15:0] c);
    analogIn <= {v, c};
  endtask
  // keys last one clock; the value word is scrambled once released
  task automatic pnl(input logic [5:0] k, input logic [15:0] f, input logic [1:0] pw);
    panelIn <= {k, f, pw};
    @(posedge ref_clk);
    panelIn <= {6'h00, ~f, 2'b00};
  endtask
  task automatic nwk(input logic [5:0] k, input logic [15:0] f);
    netIn <= {k, f};
    @(posedge ref_clk);
    netIn <= {6'h00, ~f};
  endtask
endmodule

// ===== oms_mode_selector.sv
// module: operation mode selector with its APB register file
`timescale 1ns/1ps
module oms_mode_selector (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [oms_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire oms_pkg::oms_term_s termPins,
  input wire oms_pkg::oms_analog_s analogIn,
  input wire oms_pkg::oms_panel_s panelIn,
  input wire oms_pkg::oms_net_s netIn,
  output oms_pkg::oms_drive_s driveCmd,
  output oms_pkg::oms_mode_e opMode,
  output logic panelWriteAck,
  output logic panelWriteNak
);

  logic [oms_pkg::TERM_W-1:0] termS1;
  logic [oms_pkg::TERM_W-1:0] termS2;
  logic [oms_pkg::TERM_W-1:0] termS3;
  logic [oms_pkg::TERM_W-1:0] termFilt;
  oms_pkg::oms_term_s term;

  logic [oms_pkg::SET_W-1:0] setting_reg;
  logic stopKeyEn_reg;
  oms_pkg::oms_freq_t presetLow_reg;
  oms_pkg::oms_freq_t presetMid_reg;
  oms_pkg::oms_freq_t presetHigh_reg;
  oms_pkg::oms_freq_t jog_reg;

  oms_pkg::oms_mode_e mode_reg;
  oms_pkg::oms_mode_e mode_next;
  logic run_reg;
  logic dir_reg;
  logic stopHold_reg;
  oms_pkg::oms_freq_t puFreq_reg;
  oms_pkg::oms_freq_t netFreq_reg;
  oms_pkg::oms_drive_s drive_reg;

  logic apbSetup;
  logic apbWrite;
  logic addrHit;
  logic [31:0] readWord;
  logic [31:0] statusWord;
  logic [oms_pkg::SET_W-1:0] newSetting;
  logic settingWrite;

  logic stopped;
  logic anySwitch;
  logic termRun;
  logic termDir;
  logic presetActive;
  oms_pkg::oms_freq_t presetFreq;
  oms_pkg::oms_freq_t termFreq;
  oms_pkg::oms_freq_t combFreq;
  logic runNow;
  logic dirNow;
  oms_pkg::oms_freq_t freqNow;
  logic termStartMode;
  logic panelStartMode;
  logic stopKeyHits;
  logic enterPu;
  logic enterNet;

  function automatic logic settingValid(input logic [oms_pkg::SET_W-1:0] s);
    case (s)
      oms_pkg::SET_EXT_SWITCH, oms_pkg::SET_PU_FIXED, oms_pkg::SET_EXT_FIXED,
      oms_pkg::SET_COMB_PANEL_FREQ, oms_pkg::SET_COMB_PANEL_START,
      oms_pkg::SET_SWITCHOVER: settingValid = 1'b1;
      default: settingValid = 1'b0;
    endcase
  endfunction

  // mode entered when the setting takes effect
  function automatic oms_pkg::oms_mode_e entryMode(input logic [oms_pkg::SET_W-1:0] s);
    case (s)
      oms_pkg::SET_PU_FIXED: entryMode = oms_pkg::MODE_PU;
      oms_pkg::SET_COMB_PANEL_FREQ: entryMode = oms_pkg::MODE_COMB_PF;
      oms_pkg::SET_COMB_PANEL_START: entryMode = oms_pkg::MODE_COMB_PS;
      default: entryMode = oms_pkg::MODE_EXT;
    endcase
  endfunction

  // terminal pins: three flops, a change counts once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      termS1 <= '0;
      termS2 <= '0;
      termS3 <= '0;
      termFilt <= '0;
    end
    else
    begin
      termS1 <= termPins;
      termS2 <= termS1;
      termS3 <= termS2;
      termFilt <= (termS2 & ~(termS2 ^ termS3)) | (termFilt & (termS2 ^ termS3));
    end
  end

  assign term = termFilt;

  // apb slave, zero wait states
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign pready = 1'b1;
  assign stopped = ~drive_reg.run;
  assign newSetting = pwdata[oms_pkg::CTRL_SET_LSB +: oms_pkg::SET_W];
  // setting accepted only while the motor stands
  assign settingWrite = apbWrite & (paddr == oms_pkg::OFF_CTRL) & stopped
    & settingValid(newSetting);

  always_comb
  begin
    statusWord = '0;
    statusWord[oms_pkg::STAT_MODE_LSB +: 3] = mode_reg;
    statusWord[oms_pkg::STAT_RUN_BIT] = drive_reg.run;
    statusWord[oms_pkg::STAT_REV_BIT] = drive_reg.reverse;
    statusWord[oms_pkg::STAT_HOLD_BIT] = stopHold_reg;
    statusWord[oms_pkg::STAT_FREQ_LSB +: oms_pkg::FREQ_W] = drive_reg.freq;
  end

  always_comb
  begin
    readWord = '0;
    addrHit = 1'b1;
    case (paddr)
      oms_pkg::OFF_CTRL:
      begin
        readWord[oms_pkg::CTRL_SET_LSB +: oms_pkg::SET_W] = setting_reg;
        readWord[oms_pkg::CTRL_STOP_EN_BIT] = stopKeyEn_reg;
      end
      oms_pkg::OFF_STATUS: readWord = statusWord;
      oms_pkg::OFF_PRESET_LOW: readWord[oms_pkg::FREQ_W-1:0] = presetLow_reg;
      oms_pkg::OFF_PRESET_MID: readWord[oms_pkg::FREQ_W-1:0] = presetMid_reg;
      oms_pkg::OFF_PRESET_HIGH: readWord[oms_pkg::FREQ_W-1:0] = presetHigh_reg;
      oms_pkg::OFF_JOG: readWord[oms_pkg::FREQ_W-1:0] = jog_reg;
      default: addrHit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addrHit;

  // read data captured in the setup cycle, stable through the access cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prdata <= '0;
    else if (apbSetup & ~pwrite)
      prdata <= readWord;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      setting_reg <= oms_pkg::SETTING_RESET;
      stopKeyEn_reg <= oms_pkg::STOP_KEY_EN_RESET;
    end
    else
    begin
      if (settingWrite)
        setting_reg <= newSetting;
      if (apbWrite & (paddr == oms_pkg::OFF_CTRL))
        stopKeyEn_reg <= pwdata[oms_pkg::CTRL_STOP_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      presetLow_reg <= oms_pkg::FREQ_RESET;
      presetMid_reg <= oms_pkg::FREQ_RESET;
      presetHigh_reg <= oms_pkg::FREQ_RESET;
      jog_reg <= oms_pkg::FREQ_RESET;
    end
    else if (apbWrite)
    begin
      if (paddr == oms_pkg::OFF_PRESET_LOW)
        presetLow_reg <= pwdata[oms_pkg::FREQ_W-1:0];
      if (paddr == oms_pkg::OFF_PRESET_MID)
        presetMid_reg <= pwdata[oms_pkg::FREQ_W-1:0];
      if (paddr == oms_pkg::OFF_PRESET_HIGH)
        presetHigh_reg <= pwdata[oms_pkg::FREQ_W-1:0];
      if (paddr == oms_pkg::OFF_JOG)
        jog_reg <= pwdata[oms_pkg::FREQ_W-1:0];
    end
  end

  // terminal command decode
  assign termRun = term.forwardRunInput ^ term.reverseRunInput;
  assign termDir = term.reverseRunInput & ~term.forwardRunInput;
  assign presetActive = term.presetHigh | term.presetMid | term.presetLow;

  always_comb
  begin
    if (term.presetHigh)
      presetFreq = presetHigh_reg;
    else if (term.presetMid)
      presetFreq = presetMid_reg;
    else
      presetFreq = presetLow_reg;
  end

  // terminal frequency: inching, then preset, then current or voltage analog
  always_comb
  begin
    if (term.inchingInput)
      termFreq = jog_reg;
    else if (presetActive)
      termFreq = presetFreq;
    else if (term.currentInputSelect)
      termFreq = analogIn.currFreq;
    else
      termFreq = analogIn.voltFreq;
  end

  // combined mode: preset over current analog over panel frequency
  always_comb
  begin
    if (presetActive)
      combFreq = presetFreq;
    else if (term.currentInputSelect)
      combFreq = analogIn.currFreq;
    else
      combFreq = puFreq_reg;
  end

  // mode switching
  assign anySwitch = (setting_reg == oms_pkg::SET_SWITCHOVER);

  always_comb
  begin
    mode_next = mode_reg;
    if (settingWrite)
      mode_next = entryMode(newSetting);
    else if (panelIn.panelUnitModeKey
      & ((setting_reg == oms_pkg::SET_EXT_SWITCH & stopped) | anySwitch)
      & (mode_reg == oms_pkg::MODE_EXT | mode_reg == oms_pkg::MODE_NET))
      mode_next = oms_pkg::MODE_PU;
    else if (panelIn.extModeKey
      & ((setting_reg == oms_pkg::SET_EXT_SWITCH & stopped) | anySwitch)
      & (mode_reg == oms_pkg::MODE_PU))
      mode_next = oms_pkg::MODE_EXT;
    else if (netIn.toNetCmd
      & (((setting_reg == oms_pkg::SET_EXT_SWITCH | setting_reg == oms_pkg::SET_EXT_FIXED)
      & stopped) | anySwitch)
      & (mode_reg == oms_pkg::MODE_EXT | mode_reg == oms_pkg::MODE_PU))
      mode_next = oms_pkg::MODE_NET;
    else if (netIn.toExtCmd
      & (((setting_reg == oms_pkg::SET_EXT_SWITCH | setting_reg == oms_pkg::SET_EXT_FIXED)
      & stopped) | anySwitch)
      & (mode_reg == oms_pkg::MODE_NET))
      mode_next = oms_pkg::MODE_EXT;
  end

  assign enterPu = (mode_next == oms_pkg::MODE_PU) & (mode_reg != oms_pkg::MODE_PU);
  assign enterNet = (mode_next == oms_pkg::MODE_NET) & (mode_reg != oms_pkg::MODE_NET);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      mode_reg <= oms_pkg::MODE_EXT;
    else
      mode_reg <= mode_next;
  end

  assign termStartMode = (mode_reg == oms_pkg::MODE_EXT) | (mode_reg == oms_pkg::MODE_COMB_PF);
  assign panelStartMode = (mode_reg == oms_pkg::MODE_PU) | (mode_reg == oms_pkg::MODE_COMB_PS);
  // stop key works in every mode; software can turn it off only outside the panel-start modes (MODE_PU, MODE_COMB_PS)
  assign stopKeyHits = panelIn.stopKey & (stopKeyEn_reg | panelStartMode);

  // source selection per mode
  always_comb
  begin
    case (mode_reg)
      oms_pkg::MODE_EXT:
      begin
        runNow = termRun & ~stopHold_reg;
        dirNow = termDir;
        freqNow = termFreq;
      end
      oms_pkg::MODE_PU:
      begin
        runNow = run_reg;
        dirNow = dir_reg;
        freqNow = puFreq_reg;
      end
      oms_pkg::MODE_NET:
      begin
        runNow = run_reg;
        dirNow = dir_reg;
        freqNow = netFreq_reg;
      end
      oms_pkg::MODE_COMB_PF:
      begin
        runNow = termRun & ~stopHold_reg;
        dirNow = termDir;
        freqNow = combFreq;
      end
      oms_pkg::MODE_COMB_PS:
      begin
        runNow = run_reg;
        dirNow = dir_reg;
        freqNow = termFreq;
      end
      default:
      begin
        runNow = 1'b0;
        dirNow = 1'b0;
        freqNow = oms_pkg::FREQ_RESET;
      end
    endcase
  end

  // panel and network run state; loaded with the live state on entry
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      run_reg <= 1'b0;
      dir_reg <= 1'b0;
    end
    else if (enterPu | enterNet)
    begin
      run_reg <= drive_reg.run & ~stopKeyHits;
      dir_reg <= drive_reg.reverse;
    end
    else if (stopKeyHits)
      run_reg <= 1'b0;
    else if (panelStartMode & (panelIn.runFwdKey | panelIn.runRevKey))
    begin
      run_reg <= 1'b1;
      dir_reg <= panelIn.runRevKey & ~panelIn.runFwdKey;
    end
    else if (mode_reg == oms_pkg::MODE_NET)
    begin
      if (netIn.stop)
        run_reg <= 1'b0;
      else if (netIn.runFwd | netIn.runRev)
      begin
        run_reg <= 1'b1;
        dir_reg <= netIn.runRev & ~netIn.runFwd;
      end
    end
  end

  // stop key in terminal-start modes holds until both run inputs are released
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      stopHold_reg <= 1'b0;
    else if (mode_next != mode_reg)
      stopHold_reg <= 1'b0;
    else if (termStartMode & stopKeyHits & termRun)
      stopHold_reg <= 1'b1;
    else if (~term.forwardRunInput & ~term.reverseRunInput)
      stopHold_reg <= 1'b0;
  end

  // retained frequencies; lost on reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      puFreq_reg <= oms_pkg::FREQ_RESET;
      netFreq_reg <= oms_pkg::FREQ_RESET;
    end
    else
    begin
      if (enterPu)
        puFreq_reg <= drive_reg.freq;
      else if (panelIn.freqWrite
        & (mode_reg == oms_pkg::MODE_PU | mode_reg == oms_pkg::MODE_COMB_PF))
        puFreq_reg <= panelIn.freqValue;
      if (enterNet)
        netFreq_reg <= drive_reg.freq;
      else if (netIn.freqWrite & (mode_reg == oms_pkg::MODE_NET))
        netFreq_reg <= netIn.freqValue;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      drive_reg.run <= 1'b0;
      drive_reg.reverse <= 1'b0;
      drive_reg.freq <= oms_pkg::FREQ_RESET;
    end
    else
    begin
      drive_reg.run <= runNow & ~stopKeyHits;
      drive_reg.reverse <= dirNow;
      drive_reg.freq <= freqNow;
    end
  end

  // panel parameter writes refused in terminal mode unless exempt
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      panelWriteAck <= 1'b0;
      panelWriteNak <= 1'b0;
    end
    else
    begin
      panelWriteAck <= panelIn.paramWrite
        & ((mode_reg != oms_pkg::MODE_EXT) | panelIn.paramExempt);
      panelWriteNak <= panelIn.paramWrite
        & (mode_reg == oms_pkg::MODE_EXT) & ~panelIn.paramExempt;
    end
  end

  assign driveCmd = drive_reg;
  assign opMode = mode_reg;

endmodule

// ===== oms_pkg.sv
// package: constants, types and register map of the operation mode selector
// Function
// - the active mode picks the start command source and the frequency command source
// - terminal mode: run inputs start; analog, preset and inching inputs give frequency
// - setting 0 or 2 enters terminal mode after reset
// - setting 2 locks terminal mode except for network switching; panel mode requests are refused
// - setting 0 lets a panel key change terminal mode to panel mode
// - terminal mode refuses panel setting writes except exempt ones
// - setting 1 enters panel mode when written and never leaves it
// - setting 3: panel frequency, terminal start, mode fixed
// - setting 3: a preset speed from terminals beats the panel frequency
// - setting 3: current input select on uses the current analog input
// - setting 4: terminal frequency, panel start keys, mode fixed
// - setting 6 allows panel, terminal, network switching while running
// - terminal to panel while running keeps direction and frequency until panel keys change them
// - network command terminal to network while running keeps direction and frequency
// - panel to terminal by key takes direction and frequency from terminals
// - network command panel to network keeps panel direction and frequency
// - the network master leaves network mode by a to-terminal command
// - panel switching network to panel keeps network direction and frequency
// - by default the panel stop key halts the drive in every mode
// - network mode takes start and frequency commands from the serial link
// - the mode setting changes only while the motor is stopped
package oms_pkg;

  localparam int FREQ_W = 16;
  localparam int ADDR_W = 8;
  localparam int SET_W = 3;
  localparam int TERM_W = 7;

  typedef logic [FREQ_W-1:0] oms_freq_t;

  // mode selection setting values
  localparam logic [SET_W-1:0] SET_EXT_SWITCH = 3'h0;
  localparam logic [SET_W-1:0] SET_PU_FIXED = 3'h1;
  localparam logic [SET_W-1:0] SET_EXT_FIXED = 3'h2;
  localparam logic [SET_W-1:0] SET_COMB_PANEL_FREQ = 3'h3;
  localparam logic [SET_W-1:0] SET_COMB_PANEL_START = 3'h4;
  localparam logic [SET_W-1:0] SET_SWITCHOVER = 3'h6;
  localparam logic [SET_W-1:0] SETTING_RESET = 3'h0;
  localparam logic STOP_KEY_EN_RESET = 1'b1;
  localparam oms_freq_t FREQ_RESET = 16'h0000;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PRESET_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PRESET_MID = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PRESET_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_JOG = 8'h14;

  // field positions
  localparam int CTRL_SET_LSB = 0;
  localparam int CTRL_STOP_EN_BIT = 8;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_RUN_BIT = 4;
  localparam int STAT_REV_BIT = 5;
  localparam int STAT_HOLD_BIT = 6;
  localparam int STAT_FREQ_LSB = 16;

  typedef enum logic [2:0] {
    MODE_EXT,
    MODE_PU,
    MODE_NET,
    MODE_COMB_PF,
    MODE_COMB_PS
  } oms_mode_e;

  // control terminal pins, asynchronous to ref_clk
  typedef struct packed {
    logic forwardRunInput;
    logic reverseRunInput;
    logic inchingInput;
    logic currentInputSelect;
    logic presetHigh;
    logic presetMid;
    logic presetLow;
  } oms_term_s;

  // converted analog frequency words, synchronous to ref_clk
  typedef struct packed {
    oms_freq_t voltFreq;
    oms_freq_t currFreq;
  } oms_analog_s;

  typedef struct packed {
    logic runFwdKey;
    logic runRevKey;
    logic stopKey;
    logic panelUnitModeKey;
    logic extModeKey;
    logic freqWrite;
    oms_freq_t freqValue;
    logic paramWrite;
    logic paramExempt;
  } oms_panel_s;

  typedef struct packed {
    logic toNetCmd;
    logic toExtCmd;
    logic runFwd;
    logic runRev;
    logic stop;
    logic freqWrite;
    oms_freq_t freqValue;
  } oms_net_s;

  typedef struct packed {
    logic run;
    logic reverse;
    oms_freq_t freq;
  } oms_drive_s;

endpackage

// ===== tb.sv
// testbench: mode entry, locks, priorities and hand-over of direction and frequency
`timescale 1ns/1ps
`define CHK(n, e, g) begin samplesChecked++; if ((e) !== (g)) begin errCount++; \
  $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [oms_pkg::ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready;
  logic pslverr;
  logic serr;
  logic panelWriteAck;
  logic panelWriteNak;
  oms_pkg::oms_term_s termPins;
  oms_pkg::oms_analog_s analogIn;
  oms_pkg::oms_panel_s panelIn;
  oms_pkg::oms_net_s netIn;
  oms_pkg::oms_drive_s driveCmd;
  oms_pkg::oms_mode_e opMode;
  int errCount = 0;
  int samplesChecked = 0;
  oms_mode_selector oms_mode_selector_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .termPins(termPins), .analogIn(analogIn),
    .panelIn(panelIn), .netIn(netIn), .driveCmd(driveCmd), .opMode(opMode),
    .panelWriteAck(panelWriteAck), .panelWriteNak(panelWriteNak));
  oms_far_side oms_far_side_i (.ref_clk(ref_clk), .termPins(termPins), .analogIn(analogIn),
    .panelIn(panelIn), .netIn(netIn));
  always #10 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one transfer, then an idle edge so the next setup never collides
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      errCount++;
      finalReport();
    end
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK("prdata", e, rdat)
  endtask
  // expected drive word is {run, reverse, freq}; only run is compared when stopped
  task automatic ck(input int n, input oms_pkg::oms_mode_e m, input logic [17:0] d);
    cyc(n - 1);
    @(negedge ref_clk);
    `CHK("opMode", m, opMode)
    `CHK("driveCmd", d, d[17] ? 18'(driveCmd) : {driveCmd.run, d[16:0]})
    @(posedge ref_clk);
  endtask
  task automatic pw(input logic [1:0] p, input logic a);
    oms_far_side_i.pnl(6'h00, 16'h0000, p);
    @(negedge ref_clk);
    `CHK("panelWriteAck", a, panelWriteAck)
    `CHK("panelWriteNak", !a, panelWriteNak)
    @(posedge ref_clk);
  endtask
  initial
  begin
    cyc(2);
    rst <= 1'b0;
    ck(1, oms_pkg::MODE_EXT, 18'h00000);
    rd(oms_pkg::OFF_CTRL, 32'h00000100);
    rd(8'h18, 32'h00000000);
    `CHK("pslverr", 1'b1, serr)
    $display("test reset done");
    oms_far_side_i.ana(16'h1234, 16'h0300);
    oms_far_side_i.term(7'h40);
    ck(6, oms_pkg::MODE_EXT, 18'h21234);
    apb(1'b1, oms_pkg::OFF_PRESET_LOW, 32'h00000100);
    oms_far_side_i.term(7'h41);
    ck(6, oms_pkg::MODE_EXT, 18'h20100);
    apb(1'b1, oms_pkg::OFF_JOG, 32'h00000500);
    oms_far_side_i.term(7'h51);
    ck(6, oms_pkg::MODE_EXT, 18'h20500);
    apb(1'b1, oms_pkg::OFF_PRESET_HIGH, 32'h00000700);
    oms_far_side_i.term(7'h45);
    ck(6, oms_pkg::MODE_EXT, 18'h20700);
    oms_far_side_i.term(7'h40);
    oms_far_side_i.pnl(6'h04, 16'h0000, 2'b00);
    ck(6, oms_pkg::MODE_EXT, 18'h21234);
    pw(2'b10, 1'b0);
    pw(2'b11, 1'b1);
    oms_far_side_i.pnl(6'h08, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_EXT, 18'h00000);
    ck(4, oms_pkg::MODE_EXT, 18'h00000);
    oms_far_side_i.term(7'h00);
    ck(6, oms_pkg::MODE_EXT, 18'h00000);
    oms_far_side_i.pnl(6'h04, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_PU, 18'h00000);
    pw(2'b10, 1'b1);
    oms_far_side_i.pnl(6'h02, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_EXT, 18'h00000);
    $display("test setting 0 done");
    apb(1'b1, oms_pkg::OFF_CTRL, 32'h00000102);
    oms_far_side_i.pnl(6'h04, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_EXT, 18'h00000);
    oms_far_side_i.nwk(6'h20, 16'h0000);
    ck(2, oms_pkg::MODE_NET, 18'h00000);
    oms_far_side_i.nwk(6'h10, 16'h0000);
    ck(2, oms_pkg::MODE_EXT, 18'h00000);
    $display("test setting 2 done");
    apb(1'b1, oms_pkg::OFF_CTRL, 32'h00000101);
    ck(1, oms_pkg::MODE_PU, 18'h00000);
    oms_far_side_i.pnl(6'h02, 16'h0000, 2'b00);
    oms_far_side_i.nwk(6'h20, 16'h0000);
    ck(2, oms_pkg::MODE_PU, 18'h00000);
    oms_far_side_i.pnl(6'h21, 16'h0777, 2'b00);
    ck(2, oms_pkg::MODE_PU, 18'h20777);
    apb(1'b1, oms_pkg::OFF_CTRL, 32'h00000100);
    rd(oms_pkg::OFF_CTRL, 32'h00000101);
    oms_far_side_i.pnl(6'h08, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_PU, 18'h00000);
    $display("test setting 1 done");
    apb(1'b1, oms_pkg::OFF_CTRL, 32'h00000103);
    oms_far_side_i.pnl(6'h01, 16'h0200, 2'b00);
    oms_far_side_i.term(7'h40);
    ck(6, oms_pkg::MODE_COMB_PF, 18'h20200);
    oms_far_side_i.term(7'h48);
    ck(6, oms_pkg::MODE_COMB_PF, 18'h20300);
    apb(1'b1, oms_pkg::OFF_PRESET_MID, 32'h00000400);
    oms_far_side_i.term(7'h4a);
    ck(6, oms_pkg::MODE_COMB_PF, 18'h20400);
    oms_far_side_i.pnl(6'h04, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_COMB_PF, 18'h20400);
    oms_far_side_i.term(7'h00);
    ck(6, oms_pkg::MODE_COMB_PF, 18'h00000);
    apb(1'b1, oms_pkg::OFF_CTRL, 32'h00000104);
    oms_far_side_i.pnl(6'h10, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_COMB_PS, 18'h31234);
    oms_far_side_i.pnl(6'h08, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_COMB_PS, 18'h00000);
    $display("test settings 3 and 4 done");
    apb(1'b1, oms_pkg::OFF_CTRL, 32'h00000106);
    oms_far_side_i.ana(16'h0800, 16'h0300);
    oms_far_side_i.term(7'h20);
    ck(6, oms_pkg::MODE_EXT, 18'h30800);
    oms_far_side_i.pnl(6'h04, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_PU, 18'h30800);
    oms_far_side_i.ana(16'h0900, 16'h0300);
    ck(6, oms_pkg::MODE_PU, 18'h30800);
    oms_far_side_i.nwk(6'h20, 16'h0000);
    ck(2, oms_pkg::MODE_NET, 18'h30800);
    oms_far_side_i.nwk(6'h09, 16'h0600);
    ck(2, oms_pkg::MODE_NET, 18'h20600);
    oms_far_side_i.pnl(6'h04, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_PU, 18'h20600);
    oms_far_side_i.pnl(6'h02, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_EXT, 18'h30900);
    oms_far_side_i.nwk(6'h20, 16'h0000);
    ck(2, oms_pkg::MODE_NET, 18'h30900);
    oms_far_side_i.nwk(6'h02, 16'h0000);
    ck(2, oms_pkg::MODE_NET, 18'h00000);
    oms_far_side_i.nwk(6'h04, 16'h0000);
    ck(2, oms_pkg::MODE_NET, 18'h30900);
    oms_far_side_i.ana(16'h0a00, 16'h0300);
    oms_far_side_i.nwk(6'h10, 16'h0000);
    ck(2, oms_pkg::MODE_EXT, 18'h30a00);
    apb(1'b1, oms_pkg::OFF_CTRL, 32'h00000006);
    oms_far_side_i.pnl(6'h08, 16'h0000, 2'b00);
    ck(2, oms_pkg::MODE_EXT, 18'h30a00);
    oms_far_side_i.term(7'h00);
    ck(6, oms_pkg::MODE_EXT, 18'h00000);
    $display("test setting 6 done");
    finalReport();
  end
endmodule
